// ==== core/rlp_top.sv ====
/*
  Three-channel LED PWM driver configured by an 8-bit serial instruction.
  Assumes a 10 MHz system clock, asynchronous serial pins and open-drain pads
  that sink while the enable output is high.
*/
`timescale 1ns/1ns
module rlp_top #(
  parameter logic [9:0] OSC_DIV_LAST = rlp_pkg::OSC_DIV_LAST
) (
  input  wire logic       i_sys_clk,
  input  wire logic       i_resetn,
  input  wire logic       i_chip_select_n,
  input  wire logic       i_shift_clk,
  input  wire logic       i_serial_data,
  output logic            o_channel_one_out,
  output logic            o_channel_one_oe,
  output logic            o_channel_two_out,
  output logic            o_channel_two_oe,
  output logic            o_channel_three_out,
  output logic            o_channel_three_oe,
  output logic            o_oscillator_run,
  output logic            o_period_select,
  output logic [2:0]      o_output_enable,
  output logic            o_update_pending
);
  logic [7:0]           word;
  logic                 word_valid;
  rlp_pkg::rlp_timing_t shadow;
  rlp_pkg::rlp_timing_t live;
  rlp_pkg::rlp_ctrl_t   ctrl;
  rlp_pkg::rlp_exec_t   exec_state;
  rlp_pkg::rlp_exec_t   next_exec_state;
  logic [7:0]           exec_cnt;
  logic [9:0]           osc_cnt;
  logic                 osc_tick;
  logic                 sys_phase;
  logic                 sys_tick;
  logic [5:0]           pwm_cnt;
  logic [2:0]           active;

  // Serial front end
  rlp_serial_rx u_rx (
    .i_sys_clk       (i_sys_clk),
    .i_resetn        (i_resetn),
    .i_chip_select_n (i_chip_select_n),
    .i_shift_clk     (i_shift_clk),
    .i_serial_data   (i_serial_data),
    .o_word          (word),
    .o_word_valid    (word_valid)
  );

  // Instruction decode; the test group falls through every match
  wire [2:0] opcode    = word[rlp_pkg::OP_MSB:rlp_pkg::OP_LSB];
  wire       is_duty   = word_valid && (opcode <= rlp_pkg::OP_DUTY3);
  wire       is_ctrl   = word_valid && (opcode == rlp_pkg::OP_CTRL);
  wire       is_phase  = word_valid && (opcode >= rlp_pkg::OP_PH1)
                         && (opcode <= rlp_pkg::OP_PH3);
  wire [1:0] duty_ch   = opcode[1:0];
  wire [1:0] phase_ch  = 2'(opcode - rlp_pkg::OP_PH1);
  wire       new_time  = is_duty || is_ctrl || is_phase;
  wire [2:0] ctrl_en   = {word[rlp_pkg::CTRL_EN1_BIT - 2],
                          word[rlp_pkg::CTRL_EN1_BIT - 1],
                          word[rlp_pkg::CTRL_EN1_BIT]};  // Index 0 = one

  // Immediate controls: oscillator run and output enables
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) ctrl <= rlp_pkg::RST_CTRL;
    else if (is_ctrl) begin
      ctrl.oscillator_run <= word[rlp_pkg::CTRL_OSC_BIT];
      ctrl.enable         <= ctrl_en;
    end
  end

  // Shadow copy of timing settings, written straight from decode
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) shadow <= rlp_pkg::RST_TIMING;
    else begin
      if (is_duty) shadow.duty[duty_ch] <= word[4:0];
      if (is_phase)
        shadow.phase[phase_ch] <= word[rlp_pkg::PHASE_MSB:0];
      if (is_ctrl)
        shadow.period_select <= word[rlp_pkg::CTRL_PERIOD_BIT];
    end
  end

  // Oscillator model: divider from the system clock, gated by run bit
  wire osc_wrap = (osc_cnt == OSC_DIV_LAST);
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      osc_cnt   <= 10'h000;
      osc_tick  <= 1'b0;
      sys_phase <= 1'b0;
      sys_tick  <= 1'b0;
    end else begin
      osc_tick <= ctrl.oscillator_run && osc_wrap;
      sys_tick <= ctrl.oscillator_run && osc_wrap && sys_phase;
      if (ctrl.oscillator_run) begin
        osc_cnt <= osc_wrap ? 10'h000 : osc_cnt + 10'h001;
        if (osc_wrap) sys_phase <= !sys_phase;  // System rate is osc/2
      end
    end
  end

  // Execution interval: a new timing word restarts the wait
  wire exec_done = (exec_state == rlp_pkg::EX_WAIT) && osc_tick
                   && (exec_cnt == 8'h00) && !new_time;
  always_comb begin
    next_exec_state = exec_state;
    case (exec_state)
      rlp_pkg::EX_IDLE: if (new_time) next_exec_state = rlp_pkg::EX_WAIT;
      rlp_pkg::EX_WAIT: if (exec_done) next_exec_state = rlp_pkg::EX_IDLE;
      default:          next_exec_state = rlp_pkg::EX_IDLE;
    endcase
  end

  // Counts oscillator periods, then moves shadow into the live set
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      exec_state <= rlp_pkg::EX_IDLE;
      exec_cnt   <= 8'h00;
      live       <= rlp_pkg::RST_TIMING;
    end else begin
      exec_state <= next_exec_state;
      if (new_time) exec_cnt <= rlp_pkg::EXEC_LAST;
      else if (osc_tick && exec_cnt != 8'h00)
        exec_cnt <= exec_cnt - 8'h01;
      if (exec_done) live <= shadow;
    end
  end

  // PWM counter at system rate; 64-clock period uses two counts per step
  wire [5:0] cnt_last = live.period_select ? rlp_pkg::CNT_LAST_64
                                           : rlp_pkg::CNT_LAST_32;
  wire [4:0] step     = live.period_select ? pwm_cnt[5:1] : pwm_cnt[4:0];
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) pwm_cnt <= 6'h00;
    else if (sys_tick)
      pwm_cnt <= (pwm_cnt >= cnt_last) ? 6'h00 : pwm_cnt + 6'h01;
  end

  // Three channel comparators
  genvar ch;
  generate
    for (ch = 0; ch < 3; ch++) begin : g_chan
      rlp_pwm_chan u_chan (
        .i_sys_clk (i_sys_clk),
        .i_resetn  (i_resetn),
        .i_tick    (sys_tick),
        .i_step    (step),
        .i_duty    (live.duty[ch]),
        .i_phase   (live.phase[ch]),
        .o_active  (active[ch])
      );
    end
  endgenerate

  // Open-drain pads sink only while active and enabled
  wire [2:0] next_sink = active & ctrl.enable;
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      o_channel_one_oe   <= 1'b0;
      o_channel_two_oe   <= 1'b0;
      o_channel_three_oe <= 1'b0;
    end else begin
      o_channel_one_oe   <= next_sink[0];
      o_channel_two_oe   <= next_sink[1];
      o_channel_three_oe <= next_sink[2];
    end
  end

  // Pad data is always low; status copies of the configuration
  always_ff @(posedge i_sys_clk) begin
    o_channel_one_out   <= 1'b0;
    o_channel_two_out   <= 1'b0;
    o_channel_three_out <= 1'b0;
    if (!i_resetn) begin
      o_oscillator_run <= rlp_pkg::RST_OSC;
      o_period_select  <= rlp_pkg::RST_PERIOD;
      o_output_enable  <= rlp_pkg::RST_EN;
      o_update_pending <= 1'b0;
    end else begin
      o_oscillator_run <= ctrl.oscillator_run;
      o_period_select  <= live.period_select;
      o_output_enable  <= ctrl.enable;
      o_update_pending <= (next_exec_state == rlp_pkg::EX_WAIT);
    end
  end

  // Checks on decode, execution and pads
  sequence s_last_wait;
    exec_state == rlp_pkg::EX_WAIT && exec_cnt == 8'h00 && osc_tick
      && !new_time;
  endsequence
  sequence s_applied;
    ##1 live == $past(shadow) && exec_state == rlp_pkg::EX_IDLE;
  endsequence

  a_reset_defaults: assert property (@(posedge i_sys_clk)
    !i_resetn |=> ctrl == rlp_pkg::RST_CTRL
      && live == rlp_pkg::RST_TIMING && shadow == rlp_pkg::RST_TIMING)
    else $error("reset did not restore defaults");
  a_duty_load: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    is_duty |=> shadow.duty[$past(duty_ch)] == $past(word[4:0]))
    else $error("duty word not captured");
  a_ctrl_load: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    is_ctrl |=> ctrl.oscillator_run == $past(word[3])
      && ctrl.enable == $past(ctrl_en)
      && shadow.period_select == $past(word[4]))
    else $error("control word not applied");
  a_phase_load: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    is_phase |=> shadow.phase[$past(phase_ch)] == $past(word[1:0]))
    else $error("phase word not captured");
  a_exec_apply: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    s_last_wait |-> s_applied)
    else $error("settings not applied at end of interval");
  a_exec_hold: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    exec_state == rlp_pkg::EX_WAIT && !exec_done |=> $stable(live))
    else $error("live settings changed before interval end");
  a_disabled_release: assert property (@(posedge i_sys_clk)
    disable iff (!i_resetn) !ctrl.enable[0] |=> !o_channel_one_oe)
    else $error("disabled channel one sinks current");
  a_active_sink: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    active[2] && ctrl.enable[2] |=> o_channel_three_oe)
    else $error("enabled active channel three not sinking");
endmodule

// ==== include/rlp_pkg.sv ====
/*
  Shared constants, types and helpers of the three-channel LED PWM driver.
  Assumes a 10 MHz system clock; no package is imported anywhere.
*/
package rlp_pkg;
  // Timing figures in their own units and the derived cycle counts
  localparam int CLK_PERIOD_NS   = 100;
  localparam int OSC_PERIOD_NS   = 80128;   // Nominal 12.48 kHz oscillator
  localparam int OSC_DIV_CYC     = OSC_PERIOD_NS / CLK_PERIOD_NS;
  localparam int EXEC_OSC_TICKS  = 128;     // Execution interval, osc periods
  localparam logic [9:0] OSC_DIV_LAST = 10'(OSC_DIV_CYC - 1);
  localparam logic [7:0] EXEC_LAST    = 8'(EXEC_OSC_TICKS - 1);

  // Instruction word layout
  localparam int OP_MSB          = 7;
  localparam int OP_LSB          = 5;
  localparam int CTRL_PERIOD_BIT = 4;
  localparam int CTRL_OSC_BIT    = 3;
  localparam int CTRL_EN1_BIT    = 2;       // Enables two and three follow
  localparam int PHASE_MSB       = 1;

  // Opcodes in the top three bits
  localparam logic [2:0] OP_DUTY1 = 3'h0;
  localparam logic [2:0] OP_DUTY3 = 3'h2;
  localparam logic [2:0] OP_CTRL  = 3'h3;
  localparam logic [2:0] OP_PH1   = 3'h4;
  localparam logic [2:0] OP_PH3   = 3'h6;

  // Reset values
  localparam logic [4:0] RST_DUTY   = 5'h00;
  localparam logic [1:0] RST_PHASE  = 2'h0;
  localparam logic       RST_PERIOD = 1'h0;
  localparam logic       RST_OSC    = 1'h0;
  localparam logic [2:0] RST_EN     = 3'h0;

  // PWM counter wrap points for the two period selections
  localparam logic [5:0] CNT_LAST_32 = 6'h1F;
  localparam logic [5:0] CNT_LAST_64 = 6'h3F;

  typedef struct packed {
    logic            period_select;
    logic [2:0][1:0] phase;
    logic [2:0][4:0] duty;
  } rlp_timing_t;

  typedef struct packed {
    logic       oscillator_run;
    logic [2:0] enable;                     // Index 0 is channel one
  } rlp_ctrl_t;

  typedef enum logic {EX_IDLE, EX_WAIT} rlp_exec_t;

  localparam rlp_timing_t RST_TIMING = '{
    period_select: RST_PERIOD,
    phase:         {3{RST_PHASE}},
    duty:          {3{RST_DUTY}}};
  localparam rlp_ctrl_t RST_CTRL = '{oscillator_run: RST_OSC, enable: RST_EN};

  // Phase code to counter steps of delay
  function automatic logic [4:0] rlp_phase_steps(input logic [1:0] code);
    case (code)
      2'h1:    rlp_phase_steps = 5'h04;
      2'h2:    rlp_phase_steps = 5'h08;
      2'h3:    rlp_phase_steps = 5'h10;
      default: rlp_phase_steps = 5'h00;
    endcase
  endfunction
endpackage

// ==== core/rlp_serial_rx.sv ====
/*
  Three-wire serial receiver: synchronises chip select, shift clock and data,
  shifts on every shift clock rise and hands the word over on chip select rise.
  Assumes all three pins are asynchronous to the system clock.
*/
`timescale 1ns/1ns
module rlp_serial_rx (
  input  wire logic       i_sys_clk,
  input  wire logic       i_resetn,
  input  wire logic       i_chip_select_n,
  input  wire logic       i_shift_clk,
  input  wire logic       i_serial_data,
  output logic [7:0]      o_word,
  output logic            o_word_valid
);
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic [2:0] sync3;
  logic       clk_lvl;
  logic       cs_lvl;
  logic [7:0] shreg;
  wire        clk_rise;
  wire        cs_rise;

  // Three-stage synchronisers: {chip select, shift clock, data}
  always_ff @(posedge i_sys_clk) begin
    sync1 <= {i_chip_select_n, i_shift_clk, i_serial_data};
    sync2 <= sync1;
    sync3 <= sync2;
  end

  // A change counts once stages two and three agree
  assign clk_rise = (sync2[1] == sync3[1]) && sync3[1] && !clk_lvl;
  assign cs_rise  = (sync2[2] == sync3[2]) && sync3[2] && !cs_lvl;

  // Levels, shift register and hand-over strobe
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) begin
      clk_lvl      <= 1'b0;
      cs_lvl       <= 1'b1;
      shreg        <= 8'h00;
      o_word       <= 8'h00;
      o_word_valid <= 1'b0;
    end else begin
      if (sync2[1] == sync3[1]) clk_lvl <= sync3[1];
      if (sync2[2] == sync3[2]) cs_lvl <= sync3[2];
      if (clk_rise) shreg <= {shreg[6:0], sync3[0]};
      o_word_valid <= cs_rise;
      if (cs_rise) o_word <= shreg;
    end
  end

  a_shift_msb: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    clk_rise |=> shreg == {$past(shreg[6:0]), $past(sync3[0])})
    else $error("shift register did not take data msb first");
  a_frame_load: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    cs_rise |=> o_word_valid && o_word == $past(shreg))
    else $error("word not handed over on chip select rise");
endmodule

// ==== core/rlp_pwm_chan.sv ====
/*
  One PWM channel: compares the phase-shifted step against the duty code.
  Assumes i_tick is a one-cycle system-rate enable and i_step its counter.
*/
`timescale 1ns/1ns
module rlp_pwm_chan (
  input  wire logic       i_sys_clk,
  input  wire logic       i_resetn,
  input  wire logic       i_tick,
  input  wire logic [4:0] i_step,
  input  wire logic [4:0] i_duty,
  input  wire logic [1:0] i_phase,
  output logic            o_active
);
  wire [4:0] pos;
  wire       next_active;

  // Phase delays the active window, wrapping over 32 steps
  assign pos         = i_step - rlp_pkg::rlp_phase_steps(i_phase);
  assign next_active = (pos <= i_duty);

  // Only moves on a tick, so a stopped oscillator freezes the level
  always_ff @(posedge i_sys_clk) begin
    if (!i_resetn) o_active <= 1'b0;
    else if (i_tick) o_active <= next_active;
  end

  a_freeze_hold: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    !i_tick |=> $stable(o_active))
    else $error("channel level moved without a tick");
  a_full_duty: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    i_tick && i_duty == 5'h1F |=> o_active)
    else $error("full duty code left the channel inactive");
  a_phase_start: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
    i_tick && i_step == rlp_pkg::rlp_phase_steps(i_phase) |=> o_active)
    else $error("shifted window did not start at its phase step");
endmodule

// ==== dv/rlp_host_model.sv ====
/*
  Host controller model: drives chip select, shift clock and data of the
  three-wire link. Assumes it is given the 10 MHz system clock.
*/
`timescale 1ns/1ns
module rlp_host_model #(
  parameter int HALF = 4
) (
  input  wire logic i_sys_clk,
  output logic      o_chip_select_n,
  output logic      o_shift_clk,
  output logic      o_serial_data
);
  // Idle link: select high, shift clock parked low between frames
  initial begin
    o_chip_select_n = 1'b1;
    o_shift_clk     = 1'b0;
    o_serial_data   = 1'b0;
  end

  // Wait whole system clock cycles
  task automatic idle(input int n);
    repeat (n) @(posedge i_sys_clk);
  endtask

  // One bit: data set while the clock is low, then one 800 ns clock
  task automatic shift_bit(input logic b);
    o_serial_data <= b;
    idle(HALF);
    o_shift_clk <= 1'b1;
    idle(HALF);
    o_shift_clk <= 1'b0;
  endtask

  // Eight bits, most significant first, started on a rising clock edge
  task automatic shift_word(input logic [7:0] w);
    @(posedge i_sys_clk);
    for (int i = 7; i >= 0; i--) begin
      shift_bit(w[i]);
    end
  endtask

  // Select low before the first shift clock rise
  task automatic frame_open();
    @(posedge i_sys_clk);
    o_chip_select_n <= 1'b0;
    idle(HALF);
  endtask

  // Select rise hands the word over; data is no longer held afterwards
  task automatic frame_close();
    idle(HALF);
    o_chip_select_n <= 1'b1;
    o_serial_data   <= ~o_serial_data;
    idle(2 * HALF);
  endtask

  // Whole frame; only documented opcodes or the release word are sent
  task automatic send_word(input logic [7:0] w);
    frame_open();
    shift_word(w);
    frame_close();
  endtask
endmodule

// ==== dv/rlp_top_bench.sv ====
/*
  Self-checking bench of the LED PWM driver: a host model sends words and
  the pads are measured over whole PWM periods, and over a single step once the outputs are turned off.
  Assumes a shortened oscillator of four system clocks.
*/
`timescale 1ns/1ns
module rlp_top_bench;
  localparam int OSC_CYC = 4;             // Oscillator period, sys clocks
  localparam int STEP    = 2 * OSC_CYC;   // Sys clocks per PWM step
  localparam int PER     = 32 * STEP;
  localparam int LIMIT   = 40000;

  logic       i_sys_clk;
  logic       i_resetn;
  logic       cs_n, sck, sdata;
  logic       one_out, one_oe, two_out, two_oe, three_out, three_oe;
  logic       osc_run, period_sel, pending;
  logic [2:0] out_en;
  logic [2:0] oe;
  int         failures, cmp_count, cycles, n;
  int         cnt [3];
  int         rise [3];
  logic [4:0] duty_tab [2][3] = '{'{5'h00, 5'h0F, 5'h1F},
                                  '{5'h1E, 5'h01, 5'h10}};

  assign oe = {three_oe, two_oe, one_oe};

  rlp_top #(.OSC_DIV_LAST(10'h003)) rlp_top_i (
    .i_sys_clk           (i_sys_clk),
    .i_resetn            (i_resetn),
    .i_chip_select_n     (cs_n),
    .i_shift_clk         (sck),
    .i_serial_data       (sdata),
    .o_channel_one_out   (one_out),
    .o_channel_one_oe    (one_oe),
    .o_channel_two_out   (two_out),
    .o_channel_two_oe    (two_oe),
    .o_channel_three_out (three_out),
    .o_channel_three_oe  (three_oe),
    .o_oscillator_run    (osc_run),
    .o_period_select     (period_sel),
    .o_output_enable     (out_en),
    .o_update_pending    (pending)
  );

  // Host keeps its default half period of four system clocks
  rlp_host_model rlp_host_model_i (
    .i_sys_clk       (i_sys_clk),
    .o_chip_select_n (cs_n),
    .o_shift_clk     (sck),
    .o_serial_data   (sdata)
  );

  // Clock and hang guard
  initial i_sys_clk = 1'b0;
  always #50 i_sys_clk = ~i_sys_clk;
  always @(posedge i_sys_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      failures++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    if (failures == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp,
                       input string what);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask

  task automatic check_defaults();
    @(negedge i_sys_clk);
    check(16'({osc_run, period_sel, out_en, pending}), 16'h0, "ctrl");
    check(16'({oe, one_out, two_out, three_out}), 16'h0, "pads");
  endtask

  // Counts active cycles and the first rise of each pad over len cycles
  task automatic sample_window(input int len);
    logic [2:0] prev;
    cnt = '{0, 0, 0};
    rise = '{-1, -1, -1};
    @(negedge i_sys_clk);
    prev = oe;
    for (int t = 0; t < len; t++) begin
      @(negedge i_sys_clk);
      for (int c = 0; c < 3; c++) begin
        cnt[c] += int'(oe[c] === 1'b1);
        if (oe[c] === 1'b1 && prev[c] === 1'b0 && rise[c] < 0) rise[c] = t;
      end
      prev = oe;
    end
  endtask

  // Measure only once the pending settings have landed
  task automatic wait_idle();
    n = 0;
    repeat (8) @(negedge i_sys_clk);
    while (pending !== 1'b0 && n < 2000) begin
      @(negedge i_sys_clk);
      n++;
    end
    check(16'(n < 2000), 16'h1, "apply timeout");
    repeat (2 * STEP) @(negedge i_sys_clk);
  endtask

  task automatic wait_two(input logic lvl);
    n = 0;
    while (two_oe !== lvl && n < 1000) begin
      @(negedge i_sys_clk);
      n++;
    end
  endtask

  function automatic int steps_of(input int k);
    return (k == 0) ? 0 : (4 << (k - 1));
  endfunction

  // Main sequence
  initial begin
    i_resetn = 1'b0;
    repeat (4) @(posedge i_sys_clk);
    i_resetn <= 1'b1;
    repeat (4) @(posedge i_sys_clk);
    check_defaults();
    rlp_host_model_i.send_word(8'h6F);
    check(16'({osc_run, out_en}), 16'hF, "run and enables");
    for (int r = 0; r < 2; r++) begin
      for (int c = 0; c < 3; c++)
        rlp_host_model_i.send_word({3'(c), duty_tab[r][c]});
      wait_idle();
      sample_window(PER);
      for (int c = 0; c < 3; c++)
        check(16'(cnt[c]), 16'((duty_tab[r][c] + 1) * STEP), "duty");
    end
    for (int c = 0; c < 3; c++)
      rlp_host_model_i.send_word({3'(c), 5'h14});
    rlp_host_model_i.send_word({3'h4, 3'h7, 2'h0});
    for (int k = 0; k < 4; k++) begin
      rlp_host_model_i.send_word({3'h5, 3'h7, 2'(k)});
      rlp_host_model_i.send_word({3'h6, 3'h0, 2'(3 - k)});
      wait_idle();
      sample_window(PER);
      check(16'((rise[1] - rise[0] + PER) % PER), 16'(steps_of(k) * STEP),
            "phase two");
      check(16'((rise[2] - rise[0] + PER) % PER),
            16'(steps_of(3 - k) * STEP), "phase three");
    end
    // Over-long frame selecting the 64-clock period
    rlp_host_model_i.frame_open();
    for (int i = 0; i < 4; i++) rlp_host_model_i.shift_bit(i[0]);
    rlp_host_model_i.shift_word(8'h7F);
    rlp_host_model_i.frame_close();
    check(16'({pending, period_sel}), 16'h2, "pending");
    n = 0;
    while (period_sel !== 1'b1 && n < 2000) begin
      @(negedge i_sys_clk);
      n++;
    end
    check(16'(n >= 128 * OSC_CYC - 12 && n <= 128 * OSC_CYC + 20), 16'h1,
          "exec interval");
    // Let the comparators settle on the new step size before measuring
    repeat (2 * STEP) @(negedge i_sys_clk);
    sample_window(2 * PER);
    for (int c = 0; c < 3; c++)
      check(16'(cnt[c]), 16'(21 * 2 * STEP), "long period");
    // Word shifted with select high, handed over by an empty frame
    rlp_host_model_i.shift_word(8'h7B);
    rlp_host_model_i.frame_open();
    rlp_host_model_i.frame_close();
    check(16'(out_en), 16'h6, "enables");
    wait_idle();
    sample_window(2 * PER);
    check(16'(cnt[0]), 16'h0, "disabled");
    check(16'(cnt[1]), 16'(21 * 2 * STEP), "enabled");
    // Stop the oscillator just after channel two turns on
    wait_two(1'b0);
    wait_two(1'b1);
    check(16'(n < 1000), 16'h1, "channel two rise");
    rlp_host_model_i.send_word(8'h73);
    check(16'(osc_run), 16'h0, "osc off");
    sample_window(2 * PER);
    check(16'(cnt[1]), 16'(2 * PER), "frozen two");
    check(16'(cnt[2] == 0 || cnt[2] == 2 * PER), 16'h1, "frozen three");
    rlp_host_model_i.send_word(8'h70);
    sample_window(STEP);
    check(16'(cnt[1] + cnt[2]), 16'h0, "outputs off");
    rlp_host_model_i.send_word(8'hE0);
    check(16'({osc_run, period_sel, out_en}), 16'h08, "release word");
    // Reset in mid-run with a setting still pending
    rlp_host_model_i.send_word(8'h7F);
    rlp_host_model_i.send_word(8'h05);
    @(posedge i_sys_clk);
    i_resetn <= 1'b0;
    repeat (2) @(posedge i_sys_clk);
    check_defaults();
    @(posedge i_sys_clk);
    i_resetn <= 1'b1;
    repeat (4) @(posedge i_sys_clk);
    check_defaults();
    rlp_host_model_i.send_word(8'h6F);
    wait_idle();
    sample_window(PER);
    for (int c = 0; c < 3; c++)
      check(16'(cnt[c]), 16'(STEP), "reset duty");
    check(16'(rise[0] == rise[1] && rise[1] == rise[2]), 16'h1,
          "reset phase");
    give_verdict();
  end
endmodule
